// ===== src/bju_cond.v
// Condition test evaluator for short relative jumps
`timescale 1ns/10ps
`include "bju_defines.vh"

module bju_cond (
    // Test select
    input wire [4:0] cond_i,
    // Condition flags
    input wire flag_z_i,
    input wire flag_c_i,
    input wire flag_n_i,
    input wire flag_v_i,
    input wire flag_t_i,
    // Result
    output reg taken_o
);

    wire signed_lt;

    assign signed_lt = flag_v_i ^ flag_n_i;

    // Select the flag test
    always @* begin
        case (cond_i)
            `BJU_CC_ZERO_SET: taken_o = flag_z_i;
            `BJU_CC_ZERO_CLR: taken_o = ~flag_z_i;
            `BJU_CC_CARRY_SET: taken_o = flag_c_i;
            `BJU_CC_CARRY_CLR: taken_o = ~flag_c_i;
            `BJU_CC_NEG_SET: taken_o = flag_n_i;
            `BJU_CC_NEG_CLR: taken_o = ~flag_n_i;
            `BJU_CC_OVF_SET: taken_o = flag_v_i;
            `BJU_CC_OVF_CLR: taken_o = ~flag_v_i;
            `BJU_CC_STICKY_SET: taken_o = flag_t_i;
            `BJU_CC_STICKY_CLR: taken_o = ~flag_t_i;
            `BJU_CC_SLT: taken_o = signed_lt;
            `BJU_CC_SGE: taken_o = ~signed_lt;
            `BJU_CC_SLE: taken_o = signed_lt | flag_z_i;
            `BJU_CC_SGT: taken_o = ~(signed_lt | flag_z_i);
            `BJU_CC_LS: taken_o = flag_c_i | flag_z_i;
            `BJU_CC_HI: taken_o = ~(flag_c_i | flag_z_i);
            `BJU_CC_ALWAYS: taken_o = 1'b1;
            default: taken_o = 1'b0;
        endcase
    end

endmodule // bju_cond

// ===== src/bju_defines.vh
// Constants for the branch, jump and call sequencing unit
`ifndef BJU_DEFINES_VH
`define BJU_DEFINES_VH

// Instruction classes on op_i
`define BJU_OP_SHORT 4'h0
`define BJU_OP_JMP_ACC 4'h1
`define BJU_OP_JMP_IMM16 4'h2
`define BJU_OP_JMP_REG 4'h3
`define BJU_OP_JMP_MEM 4'h4
`define BJU_OP_JMPF_REG 4'h5
`define BJU_OP_JMPF_MEM 4'h6
`define BJU_OP_JMPF_IMM24 4'h7
`define BJU_OP_CALL_REG 4'h8
`define BJU_OP_CALL_MEM 4'h9
`define BJU_OP_CALL_IMM16 4'hA
`define BJU_OP_CALL_VEC 4'hB
`define BJU_OP_CALLF_REG 4'hC
`define BJU_OP_CALLF_MEM 4'hD
`define BJU_OP_CALLF_IMM24 4'hE

// Condition tests on cond_i
`define BJU_CC_ZERO_SET 5'h00
`define BJU_CC_ZERO_CLR 5'h01
`define BJU_CC_CARRY_SET 5'h02
`define BJU_CC_CARRY_CLR 5'h03
`define BJU_CC_NEG_SET 5'h04
`define BJU_CC_NEG_CLR 5'h05
`define BJU_CC_OVF_SET 5'h06
`define BJU_CC_OVF_CLR 5'h07
`define BJU_CC_STICKY_SET 5'h08
`define BJU_CC_STICKY_CLR 5'h09
`define BJU_CC_SLT 5'h0A
`define BJU_CC_SGE 5'h0B
`define BJU_CC_SLE 5'h0C
`define BJU_CC_SGT 5'h0D
`define BJU_CC_LS 5'h0E
`define BJU_CC_HI 5'h0F
`define BJU_CC_ALWAYS 5'h10

// Cycle counts per instruction class
`define BJU_CYC_SHORT_TAKEN 5'd3
`define BJU_CYC_SHORT_NOT 5'd2
`define BJU_CYC_JMP_ACC 5'd2
`define BJU_CYC_JMP_IMM16 5'd2
`define BJU_CYC_JMP_REG 5'd3
`define BJU_CYC_JMP_MEM 5'd4
`define BJU_CYC_JMPF_REG 5'd3
`define BJU_CYC_JMPF_MEM 5'd4
`define BJU_CYC_JMPF_IMM24 5'd3
`define BJU_CYC_CALL_REG 5'd4
`define BJU_CYC_CALL_MEM 5'd5
`define BJU_CYC_CALL_IMM16 5'd5
`define BJU_CYC_CALL_VEC 5'd5
`define BJU_CYC_CALLF_REG 5'd7
`define BJU_CYC_CALLF_MEM 5'd8
`define BJU_CYC_CALLF_IMM24 5'd7

// Phase numbers inside an instruction
`define BJU_PH_BUS1 5'd1
`define BJU_PH_BUS2 5'd2
`define BJU_PH_DATA2 5'd3

// Offset of the bank byte behind a far pointer
`define BJU_BANK_OFS 16'h0002

`endif

// ===== src/bju_unit.v
// Branch, jump and call sequencing unit of a 16-bit CPU
`timescale 1ns/10ps
`include "bju_defines.vh"

module bju_unit #(
    parameter CORR_W = 4,
    parameter [15:0] VEC_BASE = 16'hFFC0
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Instruction request
    input wire start_i,
    input wire [3:0] op_i,
    input wire [4:0] cond_i,
    input wire [7:0] disp_i,
    input wire [31:0] opnd_i,
    input wire [CORR_W-1:0] corr_i,
    // Processor state
    input wire [15:0] next_pc_i,
    input wire [7:0] bank_i,
    input wire [15:0] acc_i,
    input wire flag_z_i,
    input wire flag_c_i,
    input wire flag_n_i,
    input wire flag_v_i,
    input wire flag_t_i,
    // Operand read data
    input wire [31:0] rd_data_i,
    // Status
    output reg busy_o,
    output reg done_o,
    output reg taken_o,
    output reg [4:0] cycles_o,
    output reg flag_we_o,
    // Program counter and bank load
    output reg pc_load_o,
    output reg [15:0] pc_o,
    output reg [7:0] bank_o,
    // Operand read request
    output reg rd_o,
    output reg rd_long_o,
    output reg [15:0] rd_addr_o,
    // Stack push request
    output reg push_o,
    output reg push_long_o,
    output reg [31:0] push_data_o
);

    wire cond_ok;
    reg [4:0] next_cycles;
    reg [4:0] base_cycles;
    reg uses_mem;
    reg [3:0] op;
    reg [4:0] phase;
    reg [4:0] total;
    reg [31:0] opnd;
    reg [31:0] rdat;
    reg [15:0] ret_pc;
    reg [7:0] ret_bank;
    reg [15:0] short_tgt;
    reg [15:0] next_pc;
    reg [7:0] next_bank;
    reg is_call;
    reg is_far_call;
    reg needs_read;
    reg rd_is_long;
    reg [15:0] rd_addr;

    // Flag tests for short jumps
    bju_cond u_cond (
        .cond_i(cond_i),
        .flag_z_i(flag_z_i),
        .flag_c_i(flag_c_i),
        .flag_n_i(flag_n_i),
        .flag_v_i(flag_v_i),
        .flag_t_i(flag_t_i),
        .taken_o(cond_ok)
    );

    // Base cycle count and memory use per class
    always @* begin
        uses_mem = 1'b0;
        case (op_i)
            `BJU_OP_SHORT: begin
                base_cycles = cond_ok ? `BJU_CYC_SHORT_TAKEN
                                      : `BJU_CYC_SHORT_NOT;
            end
            `BJU_OP_JMP_ACC: base_cycles = `BJU_CYC_JMP_ACC;
            `BJU_OP_JMP_IMM16: base_cycles = `BJU_CYC_JMP_IMM16;
            `BJU_OP_JMP_REG: base_cycles = `BJU_CYC_JMP_REG;
            `BJU_OP_JMP_MEM: begin
                base_cycles = `BJU_CYC_JMP_MEM;
                uses_mem = 1'b1;
            end
            `BJU_OP_JMPF_REG: base_cycles = `BJU_CYC_JMPF_REG;
            `BJU_OP_JMPF_MEM: begin
                base_cycles = `BJU_CYC_JMPF_MEM;
                uses_mem = 1'b1;
            end
            `BJU_OP_JMPF_IMM24: base_cycles = `BJU_CYC_JMPF_IMM24;
            `BJU_OP_CALL_REG: base_cycles = `BJU_CYC_CALL_REG;
            `BJU_OP_CALL_MEM: begin
                base_cycles = `BJU_CYC_CALL_MEM;
                uses_mem = 1'b1;
            end
            `BJU_OP_CALL_IMM16: base_cycles = `BJU_CYC_CALL_IMM16;
            `BJU_OP_CALL_VEC: base_cycles = `BJU_CYC_CALL_VEC;
            `BJU_OP_CALLF_REG: base_cycles = `BJU_CYC_CALLF_REG;
            `BJU_OP_CALLF_MEM: begin
                base_cycles = `BJU_CYC_CALLF_MEM;
                uses_mem = 1'b1;
            end
            `BJU_OP_CALLF_IMM24: base_cycles = `BJU_CYC_CALLF_IMM24;
            default: base_cycles = `BJU_CYC_SHORT_NOT;
        endcase
        // Memory forms add the addressing-mode correction
        next_cycles = uses_mem ? base_cycles + {{(5-CORR_W){1'b0}}, corr_i}
                               : base_cycles;
    end

    // Classify the held instruction
    always @* begin
        // Unused class code 4'hF must not push anything
        is_call = (op >= `BJU_OP_CALL_REG) &&
                  (op <= `BJU_OP_CALLF_IMM24);
        is_far_call = (op >= `BJU_OP_CALLF_REG) &&
                      (op <= `BJU_OP_CALLF_IMM24);
        needs_read = (op == `BJU_OP_JMP_MEM) || (op == `BJU_OP_JMPF_MEM) ||
                     (op == `BJU_OP_CALL_MEM) || (op == `BJU_OP_CALL_VEC) ||
                     (op == `BJU_OP_CALLF_MEM);
        rd_is_long = (op == `BJU_OP_CALLF_MEM);
        if (op == `BJU_OP_CALL_VEC) begin
            rd_addr = VEC_BASE + {11'h000, opnd[3:0], 1'b0};
        end else begin
            rd_addr = opnd[15:0];
        end
    end

    // Short jump target from sign-extended displacement
    always @* begin
        short_tgt = ret_pc + {{8{opnd[7]}}, opnd[7:0]};
    end

    // Destination of the held instruction
    always @* begin
        next_pc = pc_o;
        next_bank = bank_o;
        case (op)
            `BJU_OP_SHORT: begin
                if (taken_o) begin
                    next_pc = short_tgt;
                end
            end
            `BJU_OP_JMP_ACC: next_pc = opnd[15:0];
            `BJU_OP_JMP_IMM16: next_pc = opnd[15:0];
            `BJU_OP_JMP_REG: next_pc = opnd[15:0];
            `BJU_OP_JMP_MEM: next_pc = rdat[15:0];
            `BJU_OP_JMPF_REG: begin
                next_pc = opnd[15:0];
                next_bank = opnd[23:16];
            end
            `BJU_OP_JMPF_MEM: begin
                next_pc = rdat[15:0];
                // Bank byte may arrive in the very last cycle
                if (phase == `BJU_PH_DATA2) begin
                    next_bank = rd_data_i[7:0];
                end else begin
                    next_bank = rdat[23:16];
                end
            end
            `BJU_OP_JMPF_IMM24: begin
                next_pc = opnd[15:0];
                next_bank = opnd[23:16];
            end
            `BJU_OP_CALL_REG: next_pc = opnd[15:0];
            `BJU_OP_CALL_MEM: next_pc = rdat[15:0];
            `BJU_OP_CALL_IMM16: next_pc = opnd[15:0];
            `BJU_OP_CALL_VEC: next_pc = rdat[15:0];
            `BJU_OP_CALLF_REG: begin
                next_pc = opnd[15:0];
                next_bank = opnd[23:16];
            end
            `BJU_OP_CALLF_MEM: begin
                next_pc = rdat[15:0];
                next_bank = rdat[23:16];
            end
            `BJU_OP_CALLF_IMM24: begin
                next_pc = opnd[15:0];
                next_bank = opnd[23:16];
            end
            default: next_pc = pc_o;
        endcase
    end

    // Sequencer: accept, issue bus strobes, finish on the last cycle
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            taken_o <= 1'b0;
            cycles_o <= 5'h00;
            flag_we_o <= 1'b0;
            pc_load_o <= 1'b0;
            pc_o <= 16'h0000;
            bank_o <= 8'h00;
            rd_o <= 1'b0;
            rd_long_o <= 1'b0;
            rd_addr_o <= 16'h0000;
            push_o <= 1'b0;
            push_long_o <= 1'b0;
            push_data_o <= 32'h00000000;
            op <= 4'h0;
            phase <= 5'h00;
            total <= 5'h00;
            opnd <= 32'h00000000;
            rdat <= 32'h00000000;
            ret_pc <= 16'h0000;
            ret_bank <= 8'h00;
        end else begin
            done_o <= 1'b0;
            pc_load_o <= 1'b0;
            rd_o <= 1'b0;
            push_o <= 1'b0;
            flag_we_o <= 1'b0;
            if (!busy_o) begin
                if (start_i) begin
                    busy_o <= 1'b1;
                    op <= op_i;
                    phase <= 5'h01;
                    total <= next_cycles;
                    cycles_o <= next_cycles;
                    taken_o <= (op_i == `BJU_OP_SHORT) ? cond_ok : 1'b1;
                    ret_pc <= next_pc_i;
                    ret_bank <= bank_i;
                    pc_o <= next_pc_i;
                    bank_o <= bank_i;
                    if (op_i == `BJU_OP_SHORT) begin
                        opnd <= {24'h000000, disp_i};
                    end else if (op_i == `BJU_OP_JMP_ACC) begin
                        opnd <= {16'h0000, acc_i};
                    end else begin
                        opnd <= opnd_i;
                    end
                end
            end else begin
                phase <= phase + 5'h01;
                // First bus cycle: push return address, start operand read
                if (phase == `BJU_PH_BUS1) begin
                    if (is_call) begin
                        push_o <= 1'b1;
                        push_long_o <= is_far_call;
                        push_data_o <= is_far_call ?
                            {8'h00, ret_bank, ret_pc} : {16'h0000, ret_pc};
                    end
                    if (needs_read) begin
                        rd_o <= 1'b1;
                        rd_long_o <= rd_is_long;
                        rd_addr_o <= rd_addr;
                    end
                end
                // Second bus cycle: latch the read data; far jump via memory reads the bank word at +2
                if (phase == `BJU_PH_BUS2) begin
                    if (needs_read) begin
                        rdat[15:0] <= rd_data_i[15:0];
                        rdat[31:16] <= rd_is_long ? rd_data_i[31:16]
                                                  : 16'h0000;
                    end
                    if (op == `BJU_OP_JMPF_MEM) begin
                        rd_o <= 1'b1;
                        rd_long_o <= 1'b0;
                        rd_addr_o <= opnd[15:0] + `BJU_BANK_OFS;
                    end
                end
                if (phase == `BJU_PH_DATA2 && op == `BJU_OP_JMPF_MEM) begin
                    rdat[31:16] <= {8'h00, rd_data_i[7:0]};
                end
                // Last cycle: load PC and bank
                if (phase == total - 5'h01) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    pc_load_o <= 1'b1;
                    pc_o <= next_pc;
                    bank_o <= next_bank;
                end
            end
        end
    end

endmodule // bju_unit

// ===== tb/bju_unit_checker.sv
// Assertion checker for the branch, jump and call unit
`timescale 1ns/10ps
`include "bju_defines.vh"

module bju_unit_checker (
    // Clock, reset and request
    input wire clk_i, rst_n_i, start_i,
    input wire [3:0] op_i,
    input wire [4:0] cond_i,
    input wire [31:0] opnd_i,
    input wire [15:0] acc_i,
    input wire flag_z_i, flag_c_i, flag_n_i, flag_v_i,
    // Design outputs
    input wire busy_o, done_o, taken_o, flag_we_o, pc_load_o,
    input wire rd_o, rd_long_o, push_o, push_long_o,
    input wire [4:0] cycles_o,
    input wire [15:0] pc_o,
    input wire [7:0] bank_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Accept strobes
    wire acc_s = start_i && !busy_o && rst_n_i;
    wire sh = acc_s && op_i == `BJU_OP_SHORT;
    reg [31:0] opnd_q;
    // Operand held from accept for later comparison
    always @(posedge clk_i) begin
        if (start_i && !busy_o) begin
            opnd_q <= opnd_i;
        end
    end
    short_count_a:
        assert property (sh |=> cycles_o == (taken_o ? 5'd3 : 5'd2))
        else $error("short jump cycle count wrong");
    short_done_a:
        assert property (sh |-> ##2 (done_o ^ taken_o))
        else $error("short jump finished at wrong cycle");
    signed_lt_a:
        assert property (sh && cond_i[4:1] == 4'h5 |=> taken_o ==
            ($past(flag_v_i) ^ $past(flag_n_i) ^ $past(cond_i[0])))
        else $error("signed less test wrong");
    signed_gt_a:
        assert property (sh && cond_i[4:1] == 4'h6 |=> taken_o ==
            (($past(flag_v_i) ^ $past(flag_n_i) | $past(flag_z_i))
            ^ $past(cond_i[0])))
        else $error("signed greater test wrong");
    unsigned_a:
        assert property (sh && cond_i[4:1] == 4'h7 |=> taken_o ==
            (($past(flag_c_i) | $past(flag_z_i)) ^ $past(cond_i[0])))
        else $error("unsigned test wrong");
    acc_jump_a:
        assert property (acc_s && op_i == `BJU_OP_JMP_ACC |-> ##2
            done_o && pc_load_o && pc_o == $past(acc_i, 2))
        else $error("accumulator jump wrong");
    far_imm_a:
        assert property (acc_s && op_i == `BJU_OP_JMPF_IMM24 |-> ##3
            done_o && pc_o == opnd_q[15:0] && bank_o == opnd_q[23:16])
        else $error("far immediate jump wrong");
    far_call_a:
        assert property (acc_s && (op_i == `BJU_OP_CALLF_REG ||
            op_i == `BJU_OP_CALLF_IMM24) |-> ##7 done_o &&
            pc_o == opnd_q[15:0] && bank_o == opnd_q[23:16])
        else $error("far call wrong");
    long_push_a:
        assert property (acc_s && op_i >= `BJU_OP_CALLF_REG &&
            op_i <= `BJU_OP_CALLF_IMM24 |-> ##2 push_o && push_long_o)
        else $error("far call push not long");
    word_push_a:
        assert property (acc_s && op_i[3:2] == 2'b10 |-> ##2
            push_o && !push_long_o)
        else $error("near call push not word");
    word_read_a:
        assert property (acc_s && op_i == `BJU_OP_JMPF_MEM |-> ##2
            rd_o && !rd_long_o ##1 rd_o && !rd_long_o)
        else $error("far jump reads not words");
    flags_kept_a:
        assert property (!flag_we_o)
        else $error("flags written");
endmodule // bju_unit_checker

bind bju_unit bju_unit_checker bju_unit_checker_i (.clk_i, .rst_n_i,
    .start_i, .op_i, .cond_i, .opnd_i, .acc_i, .flag_z_i, .flag_c_i,
    .flag_n_i, .flag_v_i, .busy_o, .done_o, .taken_o, .flag_we_o,
    .pc_load_o, .rd_o, .rd_long_o, .push_o, .push_long_o, .cycles_o,
    .pc_o, .bank_o);

// ===== tb/bju_unit_tb.sv
// Self-checking bench for the branch, jump and call unit
`timescale 1ns/10ps
`include "bju_defines.vh"

module bju_unit_tb;
    localparam [15:0] VB = 16'hFF00;
    reg clk_i, rst_n_i, start_i;
    reg [3:0] op_i, corr_i;
    reg [4:0] cond_i;
    reg [7:0] disp_i, bank_i;
    reg [31:0] opnd_i, rd_data_i, r, seed;
    reg [15:0] next_pc_i, acc_i;
    reg flag_z_i, flag_c_i, flag_n_i, flag_v_i, flag_t_i;
    wire busy_o, done_o, taken_o, flag_we_o, pc_load_o;
    wire rd_o, rd_long_o, push_o, push_long_o;
    wire [4:0] cycles_o;
    wire [15:0] pc_o, rd_addr_o;
    wire [7:0] bank_o;
    wire [31:0] push_data_o;
    integer fails, checks_done, i;

    bju_unit #(.VEC_BASE(VB)) bju_unit_i (.clk_i, .rst_n_i, .start_i,
        .op_i, .cond_i, .disp_i, .opnd_i, .corr_i, .next_pc_i, .bank_i,
        .acc_i, .flag_z_i, .flag_c_i, .flag_n_i, .flag_v_i, .flag_t_i,
        .rd_data_i, .busy_o, .done_o, .taken_o, .cycles_o, .flag_we_o,
        .pc_load_o, .pc_o, .bank_o, .rd_o, .rd_long_o, .rd_addr_o,
        .push_o, .push_long_o, .push_data_o);

    // Operand memory contents as a function of address
    function automatic logic [31:0] mem(input logic [15:0] a);
        return {a ^ 16'hC3A5, a + 16'h1357};
    endfunction
    // Xorshift generator
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected outcome of a condition test
    function automatic logic cond_ok(input logic [4:0] c);
        logic s, l;
        logic [16:0] t;
        s = flag_v_i ^ flag_n_i;
        l = flag_c_i | flag_z_i;
        t = {1'b1, ~l, l, ~(s | flag_z_i), s | flag_z_i, ~s, s, ~flag_t_i,
            flag_t_i, ~flag_v_i, flag_v_i, ~flag_n_i, flag_n_i, ~flag_c_i,
            flag_c_i, ~flag_z_i, flag_z_i};
        return t[c];
    endfunction
    // Expected cycle count of the non-short classes
    function automatic logic [4:0] cyc(input logic [3:0] o, k);
        case (o)
            4'h1, 4'h2: return 5'd2;
            4'h3, 4'h5, 4'h7: return 5'd3;
            4'h4, 4'h6: return 5'd4 + k;
            4'h8: return 5'd4;
            4'h9: return 5'd5 + k;
            4'hA, 4'hB: return 5'd5;
            4'hC, 4'hE: return 5'd7;
            default: return 5'd8 + k;
        endcase
    endfunction
    // Compare and report one value
    task chk(input string nm, input logic [31:0] s, e);
        checks_done = checks_done + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Print verdict and stop
    task summarize();
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One instruction from accept to completion, entered at a falling edge
    task run(input logic [3:0] o, input logic [4:0] c, input logic hold);
        logic [15:0] ea, ep;
        logic [7:0] eb;
        logic [31:0] w, w2, pd;
        logic et, sp;
        logic [4:0] n;
        integer k;
        op_i = o;
        cond_i = c;
        start_i = 1'b1;
        ea = (o == 4'hB) ? VB + {opnd_i[3:0], 1'b0} : opnd_i[15:0];
        w = mem(ea);
        w2 = mem(ea + 16'h2);
        et = (o != 4'h0) || cond_ok(c);
        n = (o == 4'h0) ? (et ? 5'd3 : 5'd2) : cyc(o, corr_i);
        ep = opnd_i[15:0];
        eb = bank_i;
        if (o == 4'h0) ep = et ? next_pc_i + {{8{disp_i[7]}}, disp_i}
            : next_pc_i;
        if (o == 4'h1) ep = acc_i;
        if (o inside {4'h4, 4'h6, 4'h9, 4'hB, 4'hD}) ep = w[15:0];
        if (o inside {4'h5, 4'h7, 4'hC, 4'hE}) eb = opnd_i[23:16];
        if (o == 4'h6) eb = w2[7:0];
        if (o == 4'hD) eb = w[23:16];
        @(posedge clk_i);
        @(negedge clk_i);
        start_i = hold;
        k = 1;
        sp = 1'b0;
        pd = 32'h0;
        while (!done_o && k < 40) begin
            if (push_o) begin
                pd = push_data_o;
                sp = 1'b1;
            end
            @(negedge clk_i);
            k = k + 1;
        end
        chk("cycles", k, n);
        chk("count", cycles_o, n);
        chk("taken", taken_o, et);
        chk("load", pc_load_o, 1'b1);
        chk("pc", pc_o, ep);
        chk("bank", bank_o, eb);
        chk("push", sp, o >= 4'h8);
        if (o >= 4'h8) chk("pdata", pd, (o >= 4'hC) ?
            {8'h0, bank_i, next_pc_i} : {16'h0, next_pc_i});
    endtask

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Read data follows the requested address
    always @(negedge clk_i) rd_data_i <= mem(rd_addr_o);
    // Watchdog
    initial begin
        #1000000;
        fails = fails + 1;
        summarize();
    end
    // Main sequence
    initial begin
        {rst_n_i, start_i, op_i, cond_i, disp_i, opnd_i, corr_i} = 0;
        {next_pc_i, bank_i, acc_i, rd_data_i} = 0;
        {flag_z_i, flag_c_i, flag_n_i, flag_v_i, flag_t_i} = 5'h0;
        seed = 32'h362fbd95;
        fails = 0;
        checks_done = 0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        for (i = 0; i < 17 * 32; i = i + 1) begin
            r = rnd();
            {flag_z_i, flag_c_i, flag_n_i, flag_v_i, flag_t_i} = i[4:0];
            disp_i = i[0] ? 8'h80 : 8'h7F;
            next_pc_i = r[15:0];
            run(4'h0, i[9:5], 1'b0);
        end
        // Reset in the middle of a far call: its push must not appear
        op_i = 4'hC;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        rst_n_i = 1'b0;
        @(negedge clk_i);
        rst_n_i = 1'b1;
        chk("reset", {busy_o, done_o, push_o, pc_load_o, pc_o}, 32'h0);
        corr_i = 4'hF;
        opnd_i = 32'h00FF_FFFF;
        run(4'hD, 5'h0, 1'b1);
        run(4'hB, 5'h0, 1'b0);
        // Far jump via memory with no correction: bank byte comes last
        corr_i = 4'h0;
        run(4'h6, 5'h0, 1'b0);
        for (i = 0; i < 400; i = i + 1) begin
            r = rnd();
            opnd_i = rnd();
            acc_i = r[31:16];
            next_pc_i = r[15:0];
            bank_i = r[23:16];
            corr_i = r[11:8];
            disp_i = r[7:0];
            {flag_z_i, flag_c_i, flag_n_i, flag_v_i, flag_t_i} = r[28:24];
            run(r[3:0] % 4'hF, r[20:16] % 5'd17, r[5]);
        end
        start_i = 1'b0;
        @(negedge clk_i);
        summarize();
    end
endmodule // bju_unit_tb
